// ---- rtl/two_wire_serial_eeprom_slave.sv ----
/*
 * slave-side logic of a 256 x 8 two-wire serial eeprom: framing, address
 * decode, page write buffer, self-timed programming and reads.
 * assumes the serial clock and data lines are asynchronous pins; the data
 * pin is open drain and resolved outside from data_oe_n.
 */
`timescale 1ns/1ps
module two_wire_serial_eeprom_slave #(
	parameter int prog_len = eeprom_pkg::prog_cycles // programming time in clocks
) (
	input wire logic clock, // 10 MHz system clock
	input wire logic resetn, // synchronous reset, active low
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // data drive value, always low
	output logic data_oe_n, // low while pulling data low
	input wire logic strap_addr_bit0, // address strap 0
	input wire logic strap_addr_bit1, // address strap 1
	input wire logic strap_addr_bit2, // address strap 2
	input wire logic write_protect, // high makes the array read-only
	output logic busy // programming cycle running
);
	import eeprom_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; only the second stage is looked at
	logic [1:0] scl_s_q, sda_s_q, wp_s_q, strap0_s_q, strap1_s_q, strap2_s_q;
	logic scl_q, sda_q;
	always_ff @(posedge clock) begin
		if (!resetn) begin
			scl_s_q <= 2'h3;
			sda_s_q <= 2'h3;
			wp_s_q <= 2'h0;
			strap0_s_q <= 2'h0;
			strap1_s_q <= 2'h0;
			strap2_s_q <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[0], scl_in};
			sda_s_q <= {sda_s_q[0], sda_in};
			wp_s_q <= {wp_s_q[0], write_protect};
			strap0_s_q <= {strap0_s_q[0], strap_addr_bit0};
			strap1_s_q <= {strap1_s_q[0], strap_addr_bit1};
			strap2_s_q <= {strap2_s_q[0], strap_addr_bit2};
			scl_q <= scl_s_q[1];
			sda_q <= sda_s_q[1];
		end
	end

	logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
	assign scl = scl_s_q[1];
	assign sda = sda_s_q[1];
	assign scl_rise = scl && !scl_q;
	assign scl_fall = !scl && scl_q;
	assign start_det = scl && scl_q && sda_q && !sda;
	assign stop_det = scl && scl_q && !sda_q && sda;

	////////////////////////////////////////////////////////////////////////
	// storage: array and page buffer with per-byte valid bits
	logic [7:0] mem_q [mem_depth];
	logic [7:0] page_q [page_bytes];
	logic [page_bytes-1:0] pvalid_q, pvalid_d;

	////////////////////////////////////////////////////////////////////////
	// two-entry buffer between array read and the shifter, so a late
	// master never sees a torn byte; fill stalls when both slots are full
	logic [7:0] fifo_q [2];
	logic [1:0] fcount_q, fcount_d;
	logic fwp_q, fwp_d, frp_q, frp_d;
	logic fill_valid, fill_ready, drain_valid, drain_ready, fifo_flush;
	assign fill_ready = (fcount_q != 2'h2);
	assign drain_valid = (fcount_q != 2'h0);

	////////////////////////////////////////////////////////////////////////
	// protocol state
	phase_t phase_q, phase_d;
	logic [3:0] bitn_q, bitn_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d, fetch_q, fetch_d;
	logic ack_q, ack_d, drive_q, drive_d, prog_q, prog_d, gotdata_q, gotdata_d;
	logic [22:0] timer_q, timer_d;
	logic match, in_ack, write_en;
	logic [7:0] rx_byte;
	assign rx_byte = {shift_q[6:0], sda};
	assign match = (rx_byte[7:4] == type_code) &&
		(rx_byte[3:1] == {strap2_s_q[1], strap1_s_q[1], strap0_s_q[1]});
	assign in_ack = (bitn_q == 4'h8);
	// prefetch runs during the address byte so the first read bit is ready in time
	assign fill_valid = (phase_q == st_dev) || (phase_q == st_rdata) || (phase_q == st_rack);
	assign write_en = !wp_s_q[1];

	// next-state logic for framing, pointer, programming and read fetch
	always_comb begin
		phase_d = phase_q;
		bitn_d = bitn_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		ack_d = ack_q;
		drive_d = drive_q;
		prog_d = prog_q;
		gotdata_d = gotdata_q;
		timer_d = timer_q;
		pvalid_d = pvalid_q;
		fetch_d = fetch_q;
		drain_ready = 1'b0;
		fifo_flush = 1'b0;
		if (fill_valid && fill_ready) begin
			fetch_d = fetch_q + 8'h01;
		end
		if (prog_q) begin
			// inputs are dead until the timer runs out
			if (timer_q == 23'(prog_len - 1)) begin
				prog_d = 1'b0; // back to standby
				timer_d = 23'h0;
				pvalid_d = '0;
			end else begin
				timer_d = timer_q + 23'h1;
			end
			phase_d = st_idle;
			drive_d = 1'b0;
		end else if (start_det) begin
			// a start resets the framing from any state, but is ignored while programming runs
			phase_d = st_dev;
			bitn_d = 4'hF; // the clock fall that ends the start brings this to zero
			drive_d = 1'b0;
			gotdata_d = 1'b0;
			fifo_flush = 1'b1;
			fetch_d = ptr_q; // stale prefetch is dropped, refetch from the pointer
		end else if (stop_det) begin
			drive_d = 1'b0;
			phase_d = st_idle;
			if (gotdata_q && pvalid_q != '0 && write_en) begin
				prog_d = 1'b1;
			end else begin
				pvalid_d = '0;
			end
		end else if (phase_q != st_idle && phase_q != st_ignore) begin
			if (scl_rise) begin
				if (!in_ack && phase_q != st_rdata) begin
					shift_d = rx_byte; // the read shifter moves on falls only
				end else if (in_ack && phase_q == st_rack && sda) begin
					phase_d = st_ignore; // master nack ends the read
				end
			end else if (scl_fall) begin
				if (bitn_q == 4'h7) begin
					bitn_d = 4'h8;
					drive_d = 1'b0;
					case (phase_q)
						st_dev: begin
							if (shift_q[7:4] == type_code && ack_q) begin
								drive_d = 1'b1;
							end else begin
								phase_d = st_ignore;
							end
						end
						st_word: begin
							ptr_d = shift_q;
							fetch_d = shift_q;
							drive_d = 1'b1;
						end
						st_wdata: begin
							drive_d = 1'b1;
							gotdata_d = 1'b1;
						end
						st_rdata: begin
							drive_d = 1'b0; // master acknowledges
							phase_d = st_rack;
						end
						default: begin
						end
					endcase
				end else if (in_ack) begin
					bitn_d = 4'h0;
					drive_d = 1'b0;
					case (phase_q)
						st_dev: phase_d = shift_q[0] ? st_rdata : st_word;
						st_word: phase_d = st_wdata;
						st_wdata: begin
							// buffer the byte and step the low bits only
							pvalid_d[ptr_q[page_w-1:0]] = 1'b1;
							ptr_d = {ptr_q[7:page_w], ptr_q[page_w-1:0] + 4'h1};
							fetch_d = ptr_d;
						end
						default: phase_d = st_rdata;
					endcase
					if (phase_d == st_rdata) begin
						drain_ready = 1'b1;
						drive_d = !fifo_q[frp_q][7];
						ptr_d = ptr_q + 8'h01;
					end
				end else begin
					bitn_d = bitn_q + 4'h1;
					if (phase_q == st_rdata) begin
						drive_d = !shift_q[6];
						shift_d = {shift_q[6:0], 1'b1};
					end
				end
			end
		end
		if (phase_q == st_dev && scl_fall && bitn_q == 4'h7) begin
			ack_d = 1'b1;
		end
		// arm acknowledge at the eighth rising edge of the address byte
		if (phase_q == st_dev && scl_rise && bitn_q == 4'h7) begin
			ack_d = match;
		end
		// the byte sent next must be the buffered head
		if (drain_ready && drain_valid) begin
			shift_d = fifo_q[frp_q];
		end
	end

	// fifo pointer bookkeeping
	always_comb begin
		fwp_d = fwp_q;
		frp_d = frp_q;
		fcount_d = fcount_q;
		if (fifo_flush || (phase_q == st_word && scl_fall && bitn_q == 4'h7)) begin
			fwp_d = 1'b0;
			frp_d = 1'b0;
			fcount_d = 2'h0;
		end else begin
			if (fill_valid && fill_ready) begin
				fwp_d = !fwp_q;
			end
			if (drain_ready && drain_valid) begin
				frp_d = !frp_q;
			end
			fcount_d = fcount_q + 2'((fill_valid && fill_ready) ? 1 : 0) -
				2'((drain_ready && drain_valid) ? 1 : 0);
		end
	end

	// register everything; array written once per programming cycle
	always_ff @(posedge clock) begin
		if (!resetn) begin
			phase_q <= st_idle;
			bitn_q <= bit_reset;
			shift_q <= 8'hFF;
			ptr_q <= addr_reset;
			fetch_q <= addr_reset;
			ack_q <= 1'b0;
			drive_q <= 1'b0;
			prog_q <= 1'b0;
			gotdata_q <= 1'b0;
			timer_q <= 23'h0;
			pvalid_q <= '0;
			fwp_q <= 1'b0;
			frp_q <= 1'b0;
			fcount_q <= 2'h0;
			sda_out <= 1'b0;
			data_oe_n <= 1'b1;
			busy <= 1'b0;
		end else begin
			phase_q <= phase_d;
			bitn_q <= bitn_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			fetch_q <= fetch_d;
			ack_q <= ack_d;
			drive_q <= drive_d;
			prog_q <= prog_d;
			gotdata_q <= gotdata_d;
			timer_q <= timer_d;
			pvalid_q <= pvalid_d;
			fwp_q <= fwp_d;
			frp_q <= frp_d;
			fcount_q <= fcount_d;
			sda_out <= 1'b0;
			data_oe_n <= !drive_d;
			busy <= prog_d;
		end
	end

	// data storage needs no reset; erased contents are a power-up matter
	always_ff @(posedge clock) begin
		if (phase_q == st_wdata && scl_fall && in_ack) begin
			page_q[ptr_q[page_w-1:0]] <= shift_q;
		end
		if (fill_valid && fill_ready) begin
			fifo_q[fwp_q] <= mem_q[fetch_q];
		end
		if (prog_q && timer_q == 23'(prog_len - 1)) begin
			for (int i = 0; i < page_bytes; i++) begin
				if (pvalid_q[i]) begin
					mem_q[{ptr_q[7:page_w], 4'(i)}] <= page_q[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	a_busy_quiet: assert property (@(posedge clock) disable iff (!resetn)
		busy |-> data_oe_n) else $error("drove data while programming");
	// the full cycle is too long for a delay range, so the timer is bounded instead
	a_prog_len: assert property (@(posedge clock) disable iff (!resetn)
		prog_q |-> timer_q < 23'(prog_len)) else $error("programming overran");
	a_prog_step: assert property (@(posedge clock) disable iff (!resetn)
		(prog_q && $past(prog_q)) |-> timer_q == $past(timer_q) + 23'h1)
		else $error("programming timer stalled");
	a_wp_block: assert property (@(posedge clock) disable iff (!resetn)
		(stop_det && !write_en && !prog_q) |=> !prog_q) else $error("protected write began");
	a_ack_nine: assert property (@(posedge clock) disable iff (!resetn)
		$fell(data_oe_n) && phase_q != st_rdata |-> bitn_q == 4'h8)
		else $error("acknowledge outside ninth clock");
	a_page_wrap: assert property (@(posedge clock) disable iff (!resetn)
		(phase_q == st_wdata && scl_fall && in_ack && !prog_q && !start_det && !stop_det)
		|=> ptr_q[7:4] == $past(ptr_q[7:4])) else $error("page bits moved");
	a_no_prog: assert property (@(posedge clock) disable iff (!resetn)
		(stop_det && !gotdata_q && !prog_q) |=> !prog_q) else $error("dummy write programmed");
	a_start_reset: assert property (@(posedge clock) disable iff (!resetn)
		(start_det && !prog_q) |=> phase_q == st_dev && bitn_q == 4'hF)
		else $error("start did not reset framing");
	a_stop_idle: assert property (@(posedge clock) disable iff (!resetn)
		(stop_det && !start_det) |=> phase_q == st_idle && data_oe_n)
		else $error("stop left device active");
	a_fifo_count: assert property (@(posedge clock) disable iff (!resetn)
		fcount_q <= 2'h2) else $error("buffer overfilled");
endmodule

// ---- pkg/eeprom_pkg.sv ----
/*
 * constants shared by the two-wire serial eeprom slave: array size, page
 * geometry, programming time and reset values.
 * assumes a single 10 MHz system clock and a synchronous active-low reset.
 */
// Notes on behaviour
// - start is data falling while clock high
// - stop is data rising while clock high
// - one clock pulse per bit, sampled high
// - receiver acknowledges each byte by pulling low
// - address is type code, straps, direction
// - direction one reads, zero writes
// - acknowledge matching address on ninth clock
// - byte write loads pointer, programs at stop
// - ignore everything while programming runs
// - page write accepts up to sixteen bytes
// - only low four address bits increment
// - extra bytes wrap and overwrite the page
// - no acknowledge to polling while busy
// - counter holds one past last access
// - read counter wraps past end to zero
// - each master acknowledge sends next byte
// - standby after power-up, read stop, program end
// - write-protect high blocks all programming
// - programming cycle finishes within 5 ms
// - array of 256 eight-bit locations
package eeprom_pkg;
	localparam int addr_w = 8;
	localparam int mem_depth = 256;
	localparam int page_bytes = 16;
	localparam int page_w = 4;
	localparam logic [3:0] type_code = 4'h6; // arbitrary device-type code value
	localparam int clock_hz = 10000000;
	localparam int prog_time_us = 5000;
	localparam int prog_cycles = (prog_time_us * (clock_hz / 1000000));
	localparam logic [7:0] addr_reset = 8'h00;
	localparam logic [3:0] bit_reset = 4'h0;
	typedef enum logic [2:0] {st_idle, st_dev, st_word, st_wdata, st_rdata, st_rack, st_ignore}
		phase_t;
endpackage

// ---- testbench/bus_master.sv ----
/*
 * behavioural two-wire bus master, the far side of the eeprom slave.
 * assumes the bench resolves the data line with a pull-up; every change
 * is paced by the falling system clock, serial clock period 800 ns.
 */
`timescale 1ns/1ps
module bus_master (
	input wire logic clock, // bench clock
	output logic scl, // serial clock, stands high between frames
	output logic pull_n, // low while the master pulls data low
	input wire logic sda // resolved data line
);
	initial begin
		scl = 1'b1;
		pull_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	// half a serial period
	task automatic half();
		repeat (4) @(negedge clock);
	endtask
	// data moves a clock after the fall so the slave never sees it move while high
	task automatic bit_io(input logic b, output logic s);
		@(negedge clock);
		pull_n = b;
		repeat (3) @(negedge clock);
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
	endtask
	// start from idle or as a repeated start
	task automatic start();
		@(negedge clock);
		pull_n = 1'b1;
		repeat (3) @(negedge clock);
		scl = 1'b1;
		half();
		pull_n = 1'b0;
		half();
		scl = 1'b0;
	endtask
	// stop leaves both lines high, the bus idle
	task automatic stop();
		@(negedge clock);
		pull_n = 1'b0;
		repeat (3) @(negedge clock);
		scl = 1'b1;
		half();
		pull_n = 1'b1;
		half();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	// more high asks for another byte, low ends the read
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(!more, s);
	endtask
	// clock with data released until the line reads high
	task automatic recover();
		logic s;
		for (int i = 0; i < 9; i++) begin
			bit_io(1'b1, s);
			if (s)
				break;
		end
	endtask
endmodule

// ---- testbench/testbench.sv ----
/*
 * self-checking bench for the eeprom slave: byte rows, page wrap, reads,
 * polling, write protect, dummy write, address mismatch and recovery.
 * assumes bus_master as the far side and a shortened programming time.
 */
`timescale 1ns/1ps
module testbench;
	import eeprom_pkg::*;
	typedef struct packed {logic [7:0] addr; logic [7:0] data;} row_t;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic write_protect = 1'b0;
	logic [2:0] straps = 3'h5;
	logic scl, pull_n, sda_out, data_oe_n, busy, ack;
	logic [7:0] rd;
	int err_count = 0;
	int checked = 0;
	int busy_cycles = 0;
	row_t rows [4] = '{'{8'h00, 8'h3C}, '{8'h5F, 8'hA5}, '{8'hFF, 8'h01}, '{8'h10, 8'hFE}};
	wire sda = pull_n & (data_oe_n | sda_out); // open drain with pull-up
	bus_master m_u (.clock(clock), .scl(scl), .pull_n(pull_n), .sda(sda));
	two_wire_serial_eeprom_slave #(.prog_len(200)) dut_u (.clock(clock), .resetn(resetn),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .data_oe_n(data_oe_n),
		.strap_addr_bit0(straps[0]), .strap_addr_bit1(straps[1]),
		.strap_addr_bit2(straps[2]), .write_protect(write_protect), .busy(busy));
	initial begin
		forever #50 clock = ~clock;
	end
	always @(posedge clock)
		if (busy === 1'b1)
			busy_cycles++;
	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [7:0] dev(input logic rw);
		return {type_code, 3'h5, rw};
	endfunction
	task automatic send(input logic [7:0] b, input logic exp_ack);
		m_u.wbyte(b, ack);
		check("acknowledge", {7'h00, ack}, {7'h00, exp_ack});
	endtask
	task automatic write_at(input logic [7:0] a, input int n, input logic [7:0] base);
		busy_cycles = 0;
		m_u.start();
		send(dev(1'b0), 1'b1);
		send(a, 1'b1);
		for (int i = 0; i < n; i++)
			send(base + 8'(i), 1'b1);
		m_u.stop();
		repeat (2) @(negedge clock);
	endtask
	// polling is refused while busy, answered once programming ends
	task automatic wait_prog();
		int n;
		n = 0;
		check("busy", {7'h00, busy}, 8'h01);
		m_u.start();
		send(dev(1'b0), 1'b0);
		m_u.stop();
		while (busy === 1'b1 && n < 1000) begin
			@(negedge clock);
			n++;
		end
		check("busy length", 8'(busy_cycles), 8'hC8);
		m_u.start();
		send(dev(1'b0), 1'b1);
		m_u.stop();
	endtask
	task automatic read_at(input logic [7:0] a, input int n, input logic [7:0] base);
		m_u.start();
		send(dev(1'b0), 1'b1);
		send(a, 1'b1);
		m_u.start();
		send(dev(1'b1), 1'b1);
		for (int i = 0; i < n; i++) begin
			m_u.rbyte(i < n - 1, rd);
			check("read data", rd, base + 8'(i));
		end
		m_u.stop();
	endtask
	task automatic cur_read(input logic [7:0] exp);
		m_u.start();
		send(dev(1'b1), 1'b1);
		m_u.rbyte(1'b0, rd);
		check("current read", rd, exp);
		m_u.stop();
	endtask
	task automatic conclude();
		if (err_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// watchdog, well beyond the few thousand cycles the sequence needs
	initial begin
		#(60000 * 100);
		err_count++;
		conclude();
	end
	initial begin
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		check("busy", {7'h00, busy}, 8'h00);
		check("data enable", {7'h00, data_oe_n}, 8'h01);
		check("drive value", {7'h00, sda_out}, 8'h00);
		repeat (3) @(negedge clock);
		foreach (rows[i]) begin
			write_at(rows[i].addr, 1, rows[i].data);
			wait_prog();
			read_at(rows[i].addr, 1, rows[i].data);
		end
		// eighteen bytes at 3E land as 82+k at 30+k after the wrap
		write_at(8'h3E, 18, 8'h80);
		wait_prog();
		read_at(8'h30, 16, 8'h82);
		// pointer rolls over from the last location to zero
		read_at(8'hFF, 1, 8'h01);
		cur_read(8'h3C);
		// protected write is acknowledged but never programmed
		write_protect = 1'b1;
		write_at(8'h5F, 1, 8'h00);
		check("busy", {7'h00, busy}, 8'h00);
		read_at(8'h5F, 1, 8'hA5);
		write_protect = 1'b0;
		// dummy write moves the pointer only
		write_at(8'h10, 0, 8'h00);
		check("busy", {7'h00, busy}, 8'h00);
		cur_read(8'hFE);
		// other strap value is left alone
		m_u.start();
		send({type_code, 3'h4, 1'b0}, 1'b0);
		m_u.stop();
		// abandon a transfer mid byte, then recover with a start
		m_u.start();
		send(dev(1'b0), 1'b1);
		m_u.recover();
		read_at(8'h00, 1, 8'h3C);
		conclude();
	end
endmodule
